// ===== rtl/rpps_pkg.sv
package rpps_pkg;

   // ****************************************************************
   // Constants
   // ****************************************************************
   localparam logic [11:0] RPPS_PANEL_SAVE_ADDR  = 12'h000;
   localparam logic [11:0] RPPS_PANEL_START_ADDR = 12'hfff;
   localparam logic [11:0] RPPS_RESET_PC         = 12'hfff;
   localparam int          RPPS_INIT_CLOCKS      = 34;
   localparam logic [5:0]  RPPS_INIT_COUNT       = 6'h22;
   localparam int          RPPS_MIN_REQ_CLOCKS   = 58;
   localparam int          RPPS_WORST_STATES     = 28;
   localparam logic [2:0]  RPPS_STATE_LAST       = 3'h5;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      RPPS_SEQ_FETCH = 3'b000,
      RPPS_SEQ_HALT  = 3'b001,
      RPPS_SEQ_PANEL = 3'b010,
      RPPS_SEQ_DMA   = 3'b011,
      RPPS_SEQ_INT   = 3'b100,
      RPPS_SEQ_RESET = 3'b101
   } rpps_seq_t;

   typedef struct packed {
      logic input_timing_strobe;
      logic output_timing_strobe;
      logic select_timing_strobe;
   } rpps_strobe_t;

   typedef struct packed {
      logic panel_request_n;
      logic direct_access_request_n;
      logic peripheral_irq_request_n;
      logic run_halt_toggle_n;
      logic wait_n;
   } rpps_pins_t;

   // Instruction class decoded by the execution core.
   typedef struct packed {
      logic last_execute;
      logic exec_phase;
      logic indirect_mem_op;
      logic interrupt_on_instr;
      logic interrupt_off_instr;
      logic indirect_jump;
      logic mem_ref;
      logic io_read;
      logic io_write;
   } rpps_instr_t;

endpackage

// ===== rtl/rpps_sequencer.sv
`timescale 1ns/100ps
module rpps_sequencer
   import rpps_pkg::*;
(
   input  wire logic         clk_sys_i,
   input  wire logic         reset_n_i,
   input  wire logic         clk_en_i,
   input  wire logic         cpu_reset_n_i,
   input  wire rpps_pins_t   pins_i,
   input  wire rpps_instr_t  instr_i,
   input  wire logic [11:0]  pc_i,
   input  wire logic [11:0]  bus_data_i,
   output logic [11:0]       muxed_data_address_bus_o,
   output logic [11:0]       muxed_data_address_bus_oe_o,
   output logic              panel_mem_select_n_o,
   output logic              user_mem_select_n_o,
   output rpps_strobe_t      strobe_o,
   output rpps_seq_t         next_seq_o,
   output logic [11:0]       load_pc_o,
   output logic              load_pc_valid_o,
   output logic [11:0]       save_addr_o,
   output logic              save_pc_o,
   output logic              clear_ac_link_o,
   output logic              run_o,
   output logic              panel_mode_o,
   output logic              int_enable_o,
   output logic              dma_grant_o,
   output logic              int_grant_o,
   output logic              stall_o
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   logic [4:0] sync_c;
   logic [4:0] pin_q;
   logic       cpu_rst_a;
   logic       cpu_rst_b;
   logic       cpu_rst_c;
   logic       cpu_rst_q;

   // Three stages per pin; a change is accepted once the last two agree.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         sync_a    <= 5'h1f;
         sync_b    <= 5'h1f;
         sync_c    <= 5'h1f;
         pin_q     <= 5'h1f;
         cpu_rst_a <= 1'b1;
         cpu_rst_b <= 1'b1;
         cpu_rst_c <= 1'b1;
         cpu_rst_q <= 1'b1;
      end else if (clk_en_i) begin
         sync_a    <= pins_i;
         sync_b    <= sync_a;
         sync_c    <= sync_b;
         cpu_rst_a <= cpu_reset_n_i;
         cpu_rst_b <= cpu_rst_a;
         cpu_rst_c <= cpu_rst_b;
         for (int i = 0; i < 5; i++) begin
            if (sync_b[i] == sync_c[i]) begin
               pin_q[i] <= sync_c[i];
            end
         end
         if (cpu_rst_b == cpu_rst_c) begin
            cpu_rst_q <= cpu_rst_c;
         end
      end
   end

   logic panel_req;
   logic dma_req;
   logic irq_req;
   logic toggle_n;
   logic wait_act;
   logic cpu_rst;
   assign panel_req = !pin_q[4];
   assign dma_req   = !pin_q[3];
   assign irq_req   = !pin_q[2];
   assign toggle_n  = pin_q[1];
   assign wait_act  = !pin_q[0];
   assign cpu_rst   = !cpu_rst_q;

   // ****************************************************************
   // Timing generator
   // ****************************************************************
   logic [5:0] init_cnt;
   logic       init_done;
   logic [2:0] minor_state;
   logic       wait_hold;

   // Wait on a read holds the read wait state, on a write the hold state.
   always_comb begin
      wait_hold = 1'b0;
      if (wait_act && instr_i.io_read && minor_state == 3'h1) begin
         wait_hold = 1'b1;
      end
      if (wait_act && instr_i.io_write && minor_state == RPPS_STATE_LAST) begin
         wait_hold = 1'b1;
      end
   end

   // The generator starts only after its initialisation count expires.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         init_cnt    <= 6'h00;
         init_done   <= 1'b0;
         minor_state <= 3'h0;
      end else if (clk_en_i) begin
         if (!init_done) begin
            init_cnt <= init_cnt + 6'h01;
            if (init_cnt == RPPS_INIT_COUNT - 6'h01) begin
               init_done <= 1'b1;
            end
         end else if (!wait_hold) begin
            // Each state not held by wait costs exactly one whole clock; a held state lasts while wait stays active.
            minor_state <= (minor_state == RPPS_STATE_LAST) ? 3'h0 :
                           minor_state + 3'h1;
         end
      end
   end

   // Strobes keep running whatever the sequence, halt included.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         strobe_o <= '0;
      end else if (clk_en_i) begin
         strobe_o.input_timing_strobe  <= init_done && minor_state == 3'h1;
         strobe_o.output_timing_strobe <= init_done && minor_state == 3'h4;
         strobe_o.select_timing_strobe <= init_done && minor_state == 3'h2;
      end
   end

   // ****************************************************************
   // Run flag
   // ****************************************************************
   logic toggle_prev;

   // Run flag flips on each rising edge; sampled reset forces halt.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         toggle_prev <= 1'b1;
         run_o       <= 1'b0;
      end else if (clk_en_i) begin
         toggle_prev <= toggle_n;
         if (cpu_rst) begin
            run_o <= 1'b0;
         end else if (toggle_n && !toggle_prev) begin
            run_o <= !run_o;
         end
      end
   end

   // ****************************************************************
   // Priority network
   // ****************************************************************
   logic      sample;
   logic      masked;
   rpps_seq_t next_seq;
   assign sample = init_done && instr_i.last_execute && !wait_hold;
   assign masked = panel_mode_o;

   // Highest-priority action wins at each instruction boundary.
   always_comb begin
      next_seq = RPPS_SEQ_FETCH;
      if (cpu_rst) begin
         next_seq = RPPS_SEQ_RESET;
      end else if (panel_req && !panel_mode_o) begin
         next_seq = RPPS_SEQ_PANEL;
      end else if (!run_o) begin
         next_seq = RPPS_SEQ_HALT;
      end else if (dma_req && !masked) begin
         next_seq = RPPS_SEQ_DMA;
      end else if (irq_req && int_enable_o && !masked) begin
         next_seq = RPPS_SEQ_INT;
      end
   end

   // Sequence choice and the matching grant and load actions.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         next_seq_o      <= RPPS_SEQ_HALT;
         load_pc_o       <= RPPS_RESET_PC;
         load_pc_valid_o <= 1'b0;
         save_addr_o     <= RPPS_PANEL_SAVE_ADDR;
         save_pc_o       <= 1'b0;
         clear_ac_link_o <= 1'b0;
         dma_grant_o     <= 1'b0;
         int_grant_o     <= 1'b0;
      end else if (clk_en_i) begin
         load_pc_valid_o <= 1'b0;
         save_pc_o       <= 1'b0;
         clear_ac_link_o <= 1'b0;
         if (dma_grant_o && !dma_req) begin
            dma_grant_o <= 1'b0;
         end
         if (instr_i.io_read || instr_i.io_write) begin
            int_grant_o <= 1'b0;
         end
         if (sample || cpu_rst) begin
            next_seq_o <= next_seq;
            case (next_seq)
               RPPS_SEQ_RESET: begin
                  load_pc_o       <= RPPS_RESET_PC;
                  load_pc_valid_o <= 1'b1;
                  clear_ac_link_o <= 1'b1;
               end
               RPPS_SEQ_PANEL: begin
                  save_addr_o     <= RPPS_PANEL_SAVE_ADDR;
                  save_pc_o       <= 1'b1;
                  load_pc_o       <= RPPS_PANEL_START_ADDR;
                  load_pc_valid_o <= 1'b1;
               end
               RPPS_SEQ_DMA: begin
                  dma_grant_o <= 1'b1;
               end
               RPPS_SEQ_INT: begin
                  save_addr_o     <= 12'h000;
                  save_pc_o       <= 1'b1;
                  load_pc_o       <= 12'h001;
                  load_pc_valid_o <= 1'b1;
                  int_grant_o     <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Panel mode and interrupt enable
   // ****************************************************************
   logic exit_armed;

   // Panel mode lasts from grant until the jump that follows interrupt-on.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         panel_mode_o <= 1'b0;
         exit_armed   <= 1'b0;
      end else if (clk_en_i) begin
         if (cpu_rst) begin
            panel_mode_o <= 1'b0;
            exit_armed   <= 1'b0;
         end else if (sample && next_seq == RPPS_SEQ_PANEL) begin
            panel_mode_o <= 1'b1;
            exit_armed   <= 1'b0;
         end else if (panel_mode_o && sample) begin
            if (exit_armed && instr_i.indirect_jump) begin
               panel_mode_o <= 1'b0;
               exit_armed   <= 1'b0;
            end else begin
               exit_armed <= instr_i.interrupt_on_instr;
            end
         end
      end
   end

   // Interrupt on and off leave the interrupt enable unchanged while in panel mode.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         int_enable_o <= 1'b0;
      end else if (clk_en_i) begin
         if (cpu_rst || (sample && next_seq == RPPS_SEQ_INT)) begin
            int_enable_o <= 1'b0;
         end else if (!panel_mode_o && sample) begin
            if (instr_i.interrupt_on_instr) begin
               int_enable_o <= 1'b1;
            end else if (instr_i.interrupt_off_instr) begin
               int_enable_o <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Memory selects and bus
   // ****************************************************************
   logic use_user;
   assign use_user = !panel_mode_o || (instr_i.exec_phase && instr_i.indirect_mem_op);

   // Selects stay high and the bus floats during reset or a DMA grant.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         panel_mem_select_n_o        <= 1'b1;
         user_mem_select_n_o         <= 1'b1;
         muxed_data_address_bus_o    <= 12'h000;
         muxed_data_address_bus_oe_o <= 12'h000;
      end else if (clk_en_i) begin
         if (cpu_rst || dma_grant_o) begin
            panel_mem_select_n_o        <= 1'b1;
            user_mem_select_n_o         <= 1'b1;
            muxed_data_address_bus_oe_o <= 12'h000;
         end else begin
            panel_mem_select_n_o <= !(instr_i.mem_ref && !use_user);
            user_mem_select_n_o  <= !(instr_i.mem_ref && use_user);
            if (instr_i.io_write) begin
               // Write data stays driven through the stretched hold state.
               muxed_data_address_bus_o    <= bus_data_i;
               muxed_data_address_bus_oe_o <= 12'hfff;
            end else begin
               muxed_data_address_bus_o    <= pc_i;
               muxed_data_address_bus_oe_o <= instr_i.mem_ref ? 12'hfff : 12'h000;
            end
         end
      end
   end

   // Stall tells the core the timing generator is held or not started.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         stall_o <= 1'b1;
      end else if (clk_en_i) begin
         stall_o <= !init_done || wait_hold;
      end
   end

endmodule

// ===== tb/rpps_sequencer_asserts.sv
`timescale 1ns/100ps
// ****************************************************************
// Port checker for the request priority sequencer
// ****************************************************************
module rpps_sequencer_asserts
   import rpps_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   input  wire logic        cpu_reset_n_i,
   input  wire logic [11:0] muxed_data_address_bus_oe_o,
   input  wire logic        panel_mem_select_n_o,
   input  wire logic        user_mem_select_n_o,
   input  wire rpps_seq_t   next_seq_o,
   input  wire logic [11:0] load_pc_o,
   input  wire logic        load_pc_valid_o,
   input  wire logic [11:0] save_addr_o,
   input  wire logic        save_pc_o,
   input  wire logic        clear_ac_link_o,
   input  wire logic        run_o,
   input  wire logic        panel_mode_o,
   input  wire logic        int_enable_o,
   input  wire logic        dma_grant_o,
   input  wire logic        int_grant_o,
   input  wire logic        stall_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   logic [5:0] cnt;
   // Counts clocks since reset release, saturating, to time the start-up hold.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         cnt <= 6'h00;
      end else if (cnt != 6'h3f) begin
         cnt <= cnt + 6'h01;
      end
   end
   init_stall_a: assert property (cnt < 6'h22 |-> stall_o)
      else $error("stall dropped during start-up");
   reset_float_a: assert property ($rose(reset_n_i) |-> panel_mem_select_n_o
      && user_mem_select_n_o && muxed_data_address_bus_oe_o == 12'h000)
      else $error("bus or select active in reset");
   reset_pin_a: assert property ((!cpu_reset_n_i) [*6] |-> panel_mem_select_n_o
      && user_mem_select_n_o && muxed_data_address_bus_oe_o == 12'h000)
      else $error("bus or select active in pin reset");
   panel_entry_a: assert property (load_pc_valid_o && next_seq_o == RPPS_SEQ_PANEL
      |-> load_pc_o == 12'hfff && save_pc_o && save_addr_o == 12'h000 && panel_mode_o)
      else $error("panel entry wrong");
   reset_load_a: assert property (load_pc_valid_o && next_seq_o == RPPS_SEQ_RESET
      |-> load_pc_o == 12'hfff && clear_ac_link_o && !run_o)
      else $error("reset sequence wrong");
   panel_mask_a: assert property ($rose(dma_grant_o) || $rose(int_grant_o)
      |-> !panel_mode_o)
      else $error("grant in panel mode");
   int_entry_a: assert property ($rose(int_grant_o) |-> $past(int_enable_o) && !int_enable_o
      && load_pc_valid_o && load_pc_o == 12'h001 && next_seq_o == RPPS_SEQ_INT)
      else $error("interrupt entry wrong");
   dma_run_a: assert property ($rose(dma_grant_o) |-> run_o
      && next_seq_o == RPPS_SEQ_DMA)
      else $error("dma granted wrongly");
   sel_excl_a: assert property (!(!panel_mem_select_n_o && !user_mem_select_n_o))
      else $error("both selects low");
   panel_sel_a: assert property (!panel_mode_o && !$past(panel_mode_o, 2)
      |-> panel_mem_select_n_o)
      else $error("panel select outside panel mode");
endmodule
bind rpps_sequencer rpps_sequencer_asserts i_rpps_sequencer_asserts (.*);

// ===== tb/rpps_core_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Core stand-in issuing six-state instructions of a chosen class
// ****************************************************************
module rpps_core_model
   import rpps_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   input  wire logic        stall_i,
   input  wire rpps_instr_t kind_i,
   output rpps_instr_t      instr_o
);
   logic [2:0] state;
   // Steps the minor states; a stall freezes the instruction where it is.
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         state <= 3'h0;
      end else if (!stall_i) begin
         state <= (state == 3'h5) ? 3'h0 : state + 3'h1;
      end
   end
   // Class flags stand for the whole instruction; the last state is flagged.
   always_comb begin
      instr_o = kind_i;
      instr_o.exec_phase = (state > 3'h2);
      instr_o.last_execute = (state == 3'h5);
   end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
// ****************************************************************
// Scenario bench for the request priority sequencer
// ****************************************************************
module testbench
   import rpps_pkg::*;
;
   logic         clk_sys_i, reset_n_i, cpu_reset_n_i, psel_n, usel_n, load_v, save_v;
   logic         clr, run, pmode, ien, dgnt, ignt, stall, saw_user, saw_strb;
   rpps_pins_t   pins;
   rpps_instr_t  kind, instr;
   rpps_strobe_t strobe;
   rpps_seq_t    seq, seen_seq;
   logic [11:0]  bus, oe, load_pc, save_addr, seen_pc, seen_save;
   int           n_errors, compares, n_loads;

   rpps_sequencer i_rpps_sequencer (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .clk_en_i(1'b1), .cpu_reset_n_i(cpu_reset_n_i), .pins_i(pins), .instr_i(instr),
      .pc_i(12'h123), .bus_data_i(12'h456), .muxed_data_address_bus_o(bus),
      .muxed_data_address_bus_oe_o(oe), .panel_mem_select_n_o(psel_n),
      .user_mem_select_n_o(usel_n), .strobe_o(strobe), .next_seq_o(seq),
      .load_pc_o(load_pc), .load_pc_valid_o(load_v), .save_addr_o(save_addr),
      .save_pc_o(save_v), .clear_ac_link_o(clr), .run_o(run), .panel_mode_o(pmode),
      .int_enable_o(ien), .dma_grant_o(dgnt), .int_grant_o(ignt), .stall_o(stall));
   rpps_core_model i_rpps_core_model (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .stall_i(stall), .kind_i(kind), .instr_o(instr));

   // Records every program counter load and what the selects and strobes did.
   always @(posedge clk_sys_i) begin
      if (load_v) begin
         seen_seq <= seq;
         seen_pc <= load_pc;
         n_loads <= n_loads + 1;
      end
      if (save_v) begin
         seen_save <= save_addr;
      end
      if (!usel_n && pmode) begin
         saw_user <= 1'b1;
      end
      if (!run && strobe != 3'h0) begin
         saw_strb <= 1'b1;
      end
   end

   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   // Waits n rising edges, then to the settled middle of the cycle.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask
   // Waits for a new program counter load, bounded.
   task automatic wait_load();
      int n0;
      n0 = n_loads;
      for (int i = 0; i < 200 && n_loads == n0; i++) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk_bit(n_loads != n0, 1'b1);
   endtask
   // Ends on the rising edge that takes the current last execute state.
   task automatic wait_end();
      @(negedge clk_sys_i);
      for (int i = 0; i < 400 && !(instr.last_execute && !stall); i++) @(negedge clk_sys_i);
      @(posedge clk_sys_i);
   endtask
   task automatic do_instr(input rpps_instr_t k);
      wait_end();
      kind <= k;
      wait_end();
      kind <= '0;
      @(negedge clk_sys_i);
   endtask
   // Issues two instructions back to back, with no idle instruction between them.
   task automatic do_pair(input rpps_instr_t k1, input rpps_instr_t k2);
      wait_end();
      kind <= k1;
      wait_end();
      kind <= k2;
      wait_end();
      kind <= '0;
      @(negedge clk_sys_i);
   endtask

   task automatic t_run();
      chk_bit(run, 1'b0);
      @(posedge clk_sys_i);
      pins.run_halt_toggle_n <= 1'b0;
      cyc(6);
      pins.run_halt_toggle_n <= 1'b1;
      cyc(10);
      chk_bit(run, 1'b1);
      cyc(20);
      chk_word(12'(seq), 12'(RPPS_SEQ_FETCH));
   endtask
   task automatic t_int();
      rpps_instr_t k;
      k = '0;
      k.interrupt_on_instr = 1'b1;
      do_instr(k);
      cyc(14);
      chk_bit(ien, 1'b1);
      pins.peripheral_irq_request_n <= 1'b0;
      wait_load();
      chk_word(12'(seen_seq), 12'(RPPS_SEQ_INT));
      chk_word(seen_pc, 12'h001);
      chk_bit(ignt & !ien, 1'b1);
      @(posedge clk_sys_i);
      pins.peripheral_irq_request_n <= 1'b1;
      k = '0;
      k.io_read = 1'b1;
      do_instr(k);
      cyc(2);
      chk_bit(ignt, 1'b0);
   endtask
   task automatic t_panel();
      rpps_instr_t k;
      rpps_instr_t j;
      @(posedge clk_sys_i);
      pins.panel_request_n <= 1'b0;
      wait_load();
      chk_word(12'(seen_seq), 12'(RPPS_SEQ_PANEL));
      chk_word(seen_pc, 12'hfff);
      chk_word(seen_save, 12'h000);
      chk_bit(pmode, 1'b1);
      @(posedge clk_sys_i);
      pins.panel_request_n <= 1'b1;
      pins.direct_access_request_n <= 1'b0;
      saw_user = 1'b0;
      k = '0;
      k.indirect_mem_op = 1'b1;
      k.mem_ref = 1'b1;
      do_instr(k);
      chk_bit(saw_user, 1'b1);
      chk_bit(dgnt, 1'b0);
      k = '0;
      k.interrupt_on_instr = 1'b1;
      j = '0;
      j.indirect_jump = 1'b1;
      do_pair(k, j);
      chk_bit(ien, 1'b0);
      chk_bit(pmode, 1'b0);
      cyc(20);
      chk_bit(dgnt, 1'b1);
      pins.direct_access_request_n <= 1'b1;
      cyc(12);
      chk_bit(dgnt, 1'b0);
   endtask
   task automatic t_wait();
      rpps_instr_t k;
      for (int w = 0; w < 2; w++) begin
         k = '0;
         k.io_read = (w == 0);
         k.io_write = (w == 1);
         wait_end();
         kind <= k;
         pins.wait_n <= 1'b0;
         cyc(30);
         chk_bit(stall, 1'b1);
         if (w == 1) chk_word(oe, 12'hfff);
         pins.wait_n <= 1'b1;
         wait_end();
         kind <= '0;
         cyc(0);
         chk_bit(stall, 1'b0);
      end
   endtask
   task automatic t_reset();
      @(posedge clk_sys_i);
      cpu_reset_n_i <= 1'b0;
      wait_load();
      chk_word(12'(seen_seq), 12'(RPPS_SEQ_RESET));
      chk_word(seen_pc, 12'hfff);
      cyc(6);
      chk_bit(run | !psel_n | !usel_n, 1'b0);
      chk_word(oe, 12'h000);
      cpu_reset_n_i <= 1'b1;
      cyc(30);
      chk_word(12'(seq), 12'(RPPS_SEQ_HALT));
      chk_bit(saw_strb, 1'b1);
   endtask
   task automatic print_verdict();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Free-running system clock.
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   // Cuts a hang short after some ten thousand clocks.
   initial begin
      #400000;
      n_errors++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      {reset_n_i, cpu_reset_n_i, saw_user, saw_strb} = 4'h4;
      pins = '1;
      kind = '0;
      {n_errors, compares, n_loads} = '0;
      repeat (8) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      cyc(40);
      t_run();
      t_int();
      t_panel();
      t_wait();
      t_reset();
      print_verdict();
   end
endmodule
